/* File: sct_pkg.sv */
package sct_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   // Register byte addresses
   localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
   localparam logic [7:0] OFS_POWER_MODE = 8'h04;
   // clock_ctrl_status field positions
   localparam int unsigned BIT_FLAG = 0;
   localparam int unsigned BIT_IE = 1;
   localparam int unsigned BIT_TB = 2;
   localparam int unsigned BIT_SLOW = 4;
   localparam int unsigned BIT_CP = 5;
   // power_mode request bits
   localparam int unsigned BIT_WAIT = 0;
   localparam int unsigned BIT_HALT = 1;
   localparam logic [1:0] TB_SEL_RST = 2'h0;
   localparam logic [1:0] CP_SEL_RST = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Time-base periods in master clock cycles
   localparam int unsigned TB_PERIOD_00 = 16000;
   localparam int unsigned TB_PERIOD_01 = 32000;
   localparam int unsigned TB_PERIOD_10 = 80000;
   localparam int unsigned TB_PERIOD_11 = 200000;
   localparam int unsigned TB_W = 18;
   localparam int unsigned PS_W = 4;
   typedef logic [TB_W-1:0] sct_tbcnt_t;
   typedef logic [PS_W-1:0] sct_pscnt_t;
   typedef enum logic [1:0] {
      SCT_RUN,
      SCT_WAIT,
      SCT_ACT_HALT,
      SCT_HALT
   } sct_mode_t;
   // Last count of a slow-mode prescaler period: divisor minus one
   function automatic sct_pscnt_t presc_last(input logic [1:0] sel);
      unique case (sel)
         2'h0: presc_last = 4'h1;
         2'h1: presc_last = 4'h3;
         2'h2: presc_last = 4'h7;
         2'h3: presc_last = 4'hf;
      endcase
   endfunction
endpackage

/* File: sct_clk_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sct_clk_if;
   logic slow_select;
   logic [1:0] cpu_prescale_sel;
   logic [1:0] timebase_sel;
   logic run_en;
   logic div_tick;
   logic tb_wrap;
   modport ctl(output slow_select, output cpu_prescale_sel,
      output timebase_sel, output run_en, input div_tick, input tb_wrap);
   modport presc(input slow_select, input cpu_prescale_sel,
      output div_tick);
   modport tbase(input timebase_sel, input run_en, output tb_wrap);
endinterface
`default_nettype wire

/* File: sct_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module sct_prescaler (
   input wire logic aclk,
   input wire logic aresetn,
   sct_clk_if.presc cif
);
   sct_pkg::sct_pscnt_t cnt_r;
   sct_pkg::sct_pscnt_t last;

   assign last = sct_pkg::presc_last(cif.cpu_prescale_sel);
   // A shrinking divisor mid-period ends the period at once (>= test)
   assign cif.div_tick = !cif.slow_select || (cnt_r >= last);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= '0;
      end else if (cif.div_tick) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 4'h1;
      end
   end

   // Checking only: cycles since the last tick while divide by 16 holds
   logic [4:0] gap16_r;
   logic gap16_ok_r;

   always_ff @(posedge aclk) begin
      if (!aresetn || !(cif.slow_select && cif.cpu_prescale_sel == 2'h3)) begin
         gap16_r <= '0;
         gap16_ok_r <= 1'b0;
      end else if (cif.div_tick) begin
         gap16_r <= '0;
         gap16_ok_r <= 1'b1;
      end else begin
         gap16_r <= gap16_r + 5'h01;
      end
   end

   a_div2_alternate: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (cif.slow_select && cif.cpu_prescale_sel == 2'h0)[*2] ##0 cif.div_tick
      |=> !cif.div_tick)
      else $error("Divide by 2 ticked twice in a row");
   a_div16_gap: assert property (@(posedge aclk) disable iff (!aresetn)
      cif.slow_select && cif.cpu_prescale_sel == 2'h3 && gap16_ok_r
      |-> cif.div_tick == (gap16_r == 5'h0f))
      else $error("Divide by 16 period wrong");
endmodule // sct_prescaler
`default_nettype wire

/* File: sct_timebase.sv */
`timescale 1ns/1ps
`default_nettype none
module sct_timebase #(
   parameter int unsigned P00 = sct_pkg::TB_PERIOD_00,
   parameter int unsigned P01 = sct_pkg::TB_PERIOD_01,
   parameter int unsigned P10 = sct_pkg::TB_PERIOD_10,
   parameter int unsigned P11 = sct_pkg::TB_PERIOD_11
) (
   input wire logic aclk,
   input wire logic aresetn,
   sct_clk_if.tbase cif
);
   sct_pkg::sct_tbcnt_t cnt_r;
   sct_pkg::sct_tbcnt_t gap_r;
   logic [1:0] act_sel_r;
   logic seen_r;

   function automatic sct_pkg::sct_tbcnt_t tb_last(input logic [1:0] s);
      unique case (s)
         2'h0: tb_last = sct_pkg::sct_tbcnt_t'(P00 - 1);
         2'h1: tb_last = sct_pkg::sct_tbcnt_t'(P01 - 1);
         2'h2: tb_last = sct_pkg::sct_tbcnt_t'(P10 - 1);
         2'h3: tb_last = sct_pkg::sct_tbcnt_t'(P11 - 1);
      endcase
   endfunction

   assign cif.tb_wrap = cif.run_en && (cnt_r >= tb_last(act_sel_r));

   // Counts whenever run_en is set; interrupt enable has no say here
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= '0;
      end else if (cif.tb_wrap) begin
         cnt_r <= '0;
      end else if (cif.run_en) begin
         cnt_r <= cnt_r + 18'h1;
      end
   end

   // New selection only picked up at a period boundary, no time shift
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_sel_r <= sct_pkg::TB_SEL_RST;
      end else if (cif.tb_wrap) begin
         act_sel_r <= cif.timebase_sel;
      end
   end

   // Independent gap measurement for checking only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gap_r <= '0;
         seen_r <= 1'b0;
      end else if (cif.tb_wrap) begin
         gap_r <= '0;
         seen_r <= 1'b1;
      end else if (cif.run_en) begin
         gap_r <= gap_r + 18'h1;
      end
   end

   a_tb_period: assert property (@(posedge aclk) disable iff (!aresetn)
      cif.tb_wrap && seen_r |-> gap_r == tb_last(act_sel_r))
      else $error("Time-base period length wrong");
   a_tb_deferred: assert property (@(posedge aclk)
      disable iff (!aresetn)
      !cif.tb_wrap |=> $stable(act_sel_r))
      else $error("Time-base selection changed mid-period");
   a_tb_counting: assert property (@(posedge aclk)
      disable iff (!aresetn)
      cif.run_en && !cif.tb_wrap |=> cnt_r == $past(cnt_r) + 18'h1)
      else $error("Time-base counter stalled");
endmodule // sct_timebase
`default_nettype wire

/* File: sct_clock_ctrl.sv */
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sct_clock_ctrl #(
   parameter int unsigned TB_PERIOD_00 = sct_pkg::TB_PERIOD_00,
   parameter int unsigned TB_PERIOD_01 = sct_pkg::TB_PERIOD_01,
   parameter int unsigned TB_PERIOD_10 = sct_pkg::TB_PERIOD_10,
   parameter int unsigned TB_PERIOD_11 = sct_pkg::TB_PERIOD_11
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic wake_irq,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic osc_irq,
   output logic [1:0] power_mode
);
   sct_clk_if cif ();

   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic aw_got_r, w_got_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [1:0] aw_hit, ar_hit;
   logic wr_fire, rd_fire, wr_status, wr_mode, rd_status;
   logic slow_r, ie_r, flag_r, osc_irq_r;
   logic [1:0] cp_r, tb_r;
   logic wait_req, halt_req;
   sct_pkg::sct_mode_t mode_r;
   logic cpu_clk_en_r, periph_clk_en_r;

   function automatic logic [1:0] reg_hit(input logic [7:0] a);
      reg_hit = {a == sct_pkg::OFS_POWER_MODE,
         a == sct_pkg::OFS_CTRL_STATUS};
   endfunction

   sct_prescaler u_presc (
      .aclk(aclk),
      .aresetn(aresetn),
      .cif(cif.presc)
   );

   sct_timebase #(
      .P00(TB_PERIOD_00),
      .P01(TB_PERIOD_01),
      .P10(TB_PERIOD_10),
      .P11(TB_PERIOD_11)
   ) u_tbase (
      .aclk(aclk),
      .aresetn(aresetn),
      .cif(cif.tbase)
   );

   assign cif.slow_select = slow_r;
   assign cif.cpu_prescale_sel = cp_r;
   assign cif.timebase_sel = tb_r;
   // Oscillator stops in plain halt, so the time base freezes there
   assign cif.run_en = (mode_r != sct_pkg::SCT_HALT);

   // Write channel: address and data taken in either order, one at a time
   assign aw_hit = reg_hit(awaddr_r);
   assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
   assign wr_status = wr_fire && aw_hit[0] && wstrb_r[0];
   assign wr_mode = wr_fire && aw_hit[1] && wstrb_r[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         aw_got_r <= 1'b0;
         awaddr_r <= '0;
      end else if (s_axi_awvalid && awready_r) begin
         awready_r <= 1'b0;
         aw_got_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end else if (bvalid_r && s_axi_bready) begin
         awready_r <= 1'b1;
         aw_got_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_r <= 1'b1;
         w_got_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else if (s_axi_wvalid && wready_r) begin
         wready_r <= 1'b0;
         w_got_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end else if (bvalid_r && s_axi_bready) begin
         wready_r <= 1'b1;
         w_got_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= sct_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r <= (|aw_hit) ? sct_pkg::RESP_OKAY
            : sct_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // Read channel: data one edge after the address is taken
   assign ar_hit = reg_hit(s_axi_araddr);
   assign rd_fire = s_axi_arvalid && arready_r;
   assign rd_status = rd_fire && ar_hit[0];

   always_comb begin
      rdata_nxt = '0;
      if (ar_hit[0]) begin
         rdata_nxt[sct_pkg::BIT_FLAG] = flag_r;
         rdata_nxt[sct_pkg::BIT_IE] = ie_r;
         rdata_nxt[sct_pkg::BIT_TB +: 2] = tb_r;
         rdata_nxt[sct_pkg::BIT_SLOW] = slow_r;
         rdata_nxt[sct_pkg::BIT_CP +: 2] = cp_r;
      end else if (ar_hit[1]) begin
         rdata_nxt[1:0] = mode_r;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= sct_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rdata_nxt;
         rresp_r <= (|ar_hit) ? sct_pkg::RESP_OKAY
            : sct_pkg::RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
      end
   end

   // Software fields; flag bit is read-only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slow_r <= 1'b0;
         ie_r <= 1'b0;
         tb_r <= sct_pkg::TB_SEL_RST;
         cp_r <= sct_pkg::CP_SEL_RST;
      end else if (wr_status) begin
         slow_r <= wdata_r[sct_pkg::BIT_SLOW];
         ie_r <= wdata_r[sct_pkg::BIT_IE];
         tb_r <= wdata_r[sct_pkg::BIT_TB +: 2];
         cp_r <= wdata_r[sct_pkg::BIT_CP +: 2];
      end
   end

   // Set wins over the read clear so no period end is lost
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_r <= 1'b0;
      end else if (cif.tb_wrap) begin
         flag_r <= 1'b1;
      end else if (rd_status) begin
         flag_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_irq_r <= 1'b0;
      end else begin
         osc_irq_r <= flag_r && ie_r;
      end
   end

   // Power modes: requests from the core via the power_mode register
   assign wait_req = wr_mode && wdata_r[sct_pkg::BIT_WAIT];
   assign halt_req = wr_mode && wdata_r[sct_pkg::BIT_HALT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= sct_pkg::SCT_RUN;
      end else begin
         unique case (mode_r)
            sct_pkg::SCT_RUN: begin
               if (halt_req) begin
                  mode_r <= ie_r ? sct_pkg::SCT_ACT_HALT
                     : sct_pkg::SCT_HALT;
               end else if (wait_req) begin
                  mode_r <= sct_pkg::SCT_WAIT;
               end
            end
            sct_pkg::SCT_WAIT, sct_pkg::SCT_ACT_HALT: begin
               if (wake_irq || osc_irq_r) begin
                  mode_r <= sct_pkg::SCT_RUN;
               end
            end
            sct_pkg::SCT_HALT: begin
               if (wake_irq) begin
                  mode_r <= sct_pkg::SCT_RUN;
               end
            end
         endcase
      end
   end

   // Peripherals keep the divided clock in wait, which gives slow-wait
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_clk_en_r <= 1'b0;
         periph_clk_en_r <= 1'b0;
      end else begin
         cpu_clk_en_r <= cif.div_tick && (mode_r == sct_pkg::SCT_RUN);
         periph_clk_en_r <= cif.div_tick &&
            (mode_r == sct_pkg::SCT_RUN || mode_r == sct_pkg::SCT_WAIT);
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign cpu_clk_en = cpu_clk_en_r;
   assign periph_clk_en = periph_clk_en_r;
   assign osc_irq = osc_irq_r;
   assign power_mode = mode_r;

   a_reset_run: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(!aresetn) |-> !slow_r && mode_r == sct_pkg::SCT_RUN)
      else $error("Not in normal run mode after reset");
   a_full_rate: assert property (@(posedge aclk) disable iff (!aresetn)
      (!slow_r && mode_r == sct_pkg::SCT_RUN)[*2] |-> cpu_clk_en_r)
      else $error("CPU clock not full rate with slow mode off");
   a_flag_on_wrap: assert property (@(posedge aclk)
      disable iff (!aresetn)
      cif.tb_wrap |=> flag_r ##1 (flag_r || $past(rd_status)))
      else $error("Flag not set at period end");
   a_flag_read_clr: assert property (@(posedge aclk)
      disable iff (!aresetn)
      rd_status && !cif.tb_wrap |=> !flag_r && s_axi_rvalid)
      else $error("Status read did not clear flag");
   a_irq_follows: assert property (@(posedge aclk)
      disable iff (!aresetn)
      flag_r && ie_r |=> osc_irq_r)
      else $error("Interrupt not raised from set flag");
   a_irq_gated: assert property (@(posedge aclk) disable iff (!aresetn)
      !ie_r [*2] |-> !osc_irq_r)
      else $error("Interrupt raised while disabled");
   a_active_halt: assert property (@(posedge aclk)
      disable iff (!aresetn)
      mode_r == sct_pkg::SCT_RUN && halt_req |=> mode_r == ($past(ie_r) ?
      sct_pkg::SCT_ACT_HALT : sct_pkg::SCT_HALT))
      else $error("Halt entered wrong mode");
   a_halt_held: assert property (@(posedge aclk) disable iff (!aresetn)
      mode_r == sct_pkg::SCT_HALT && !wake_irq |=>
      mode_r == sct_pkg::SCT_HALT)
      else $error("Plain halt left without a wake request");
   a_wait_entry: assert property (@(posedge aclk)
      disable iff (!aresetn)
      mode_r == sct_pkg::SCT_RUN && wait_req && !halt_req |=>
      mode_r == sct_pkg::SCT_WAIT)
      else $error("Wait request did not enter wait");
   a_cpu_stopped: assert property (@(posedge aclk)
      disable iff (!aresetn)
      mode_r != sct_pkg::SCT_RUN |=> !cpu_clk_en_r)
      else $error("CPU clock ran outside run mode");
   a_slow_wait: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode_r == sct_pkg::SCT_WAIT && slow_r && cp_r == 2'h0 && !wake_irq)[*3]
      |-> periph_clk_en_r || $past(periph_clk_en_r))
      else $error("Slow-wait lost the divided clock");
endmodule // sct_clock_ctrl
`default_nettype wire

/* File: slow_clock_and_timebase_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module slow_clock_and_timebase_test;
   // Short periods keep the run brief; every period expectation uses these
   localparam int unsigned P0 = 20;
   localparam int unsigned P1 = 30;
   localparam int unsigned P2 = 40;
   localparam int unsigned P3 = 50;
   typedef struct {
      logic slow;
      logic [1:0] cp;
      logic [1:0] tb;
      int div;
      int per;
   } sct_row_t;
   sct_row_t rows [5] = '{
      '{1'b0, 2'h3, 2'h1, 1, P1},
      '{1'b1, 2'h0, 2'h2, 2, P2},
      '{1'b1, 2'h1, 2'h3, 4, P3},
      '{1'b1, 2'h2, 2'h1, 8, P1},
      '{1'b1, 2'h3, 2'h0, 16, P0}
   };
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, wake_irq;
   logic cpu_clk_en, periph_clk_en, osc_irq, osc_q;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd, wd;
   logic [1:0] bresp, rresp, rs, power_mode;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;
   int last_rise = 0;
   int prev_rise = 0;
   int rise_cnt = 0;
   int c, p, k;

   sct_clock_ctrl #(.TB_PERIOD_00(P0), .TB_PERIOD_01(P1),
      .TB_PERIOD_10(P2), .TB_PERIOD_11(P3)) u_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wake_irq(wake_irq),
      .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
      .osc_irq(osc_irq), .power_mode(power_mode)
   );

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   function automatic void chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endfunction

   // Rising edges of the gated request mark the end of each period
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      osc_q <= osc_irq;
      if (osc_irq === 1'b1 && osc_q === 1'b0) begin
         prev_rise <= last_rise;
         last_rise <= cyc;
         rise_cnt <= rise_cnt + 1;
      end
      if (cyc == 20000) begin
         error_cnt++;
         stop_test();
      end
   end

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
         output logic [1:0] r);
      bit aw, w, b;
      aw = 1;
      w = 1;
      b = 1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (b) begin
         @(posedge aclk);
         if (aw && awready) begin
            aw = 0;
            awvalid <= 1'b0;
         end
         if (w && wready) begin
            w = 0;
            wvalid <= 1'b0;
         end
         if (bvalid === 1'b1) begin
            r = bresp;
            b = 0;
            bready <= 1'b0;
         end
      end
      // One edge between transfers so no ready is driven twice at once
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
         output logic [1:0] r);
      bit ar, b;
      ar = 1;
      b = 1;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (b) begin
         @(posedge aclk);
         if (ar && arready) begin
            ar = 0;
            arvalid <= 1'b0;
         end
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            b = 0;
            rready <= 1'b0;
         end
      end
      @(posedge aclk);
   endtask

   task automatic count(input int n);
      c = 0;
      p = 0;
      repeat (n) begin
         @(posedge aclk);
         c += int'(cpu_clk_en === 1'b1);
         p += int'(periph_clk_en === 1'b1);
      end
   endtask

   // Clears the flag first, otherwise the level never falls and rises again
   task automatic next_rise();
      int n;
      axi_rd(sct_pkg::OFS_CTRL_STATUS, rd, rs);
      n = rise_cnt;
      while (rise_cnt == n)
         @(posedge aclk);
   endtask

   task automatic wake();
      wake_irq <= 1'b1;
      @(posedge aclk);
      wake_irq <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask

   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, wake_irq} = 6'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK(power_mode, sct_pkg::SCT_RUN);
      axi_rd(sct_pkg::OFS_CTRL_STATUS, rd, rs);
      `CHK(rd, 32'h0000_0000);
      count(16);
      `CHK(c, 16);
      $display("reset test done");
      foreach (rows[i]) begin
         wd = {25'h0, rows[i].cp, rows[i].slow, rows[i].tb, 2'b10};
         axi_wr(sct_pkg::OFS_CTRL_STATUS, wd, rs);
         `CHK(rs, sct_pkg::RESP_OKAY);
         axi_rd(sct_pkg::OFS_CTRL_STATUS, rd, rs);
         `CHK(rd & 32'hffff_fffe, wd);
         repeat (20) @(posedge aclk);
         count(48);
         `CHK(c, 48 / rows[i].div);
         `CHK(p, 48 / rows[i].div);
         repeat (3) next_rise();
         `CHK(last_rise - prev_rise, rows[i].per);
         $display("row %0d test done", i);
      end
      // New selection written mid-period: old length first, then new
      next_rise();
      axi_wr(sct_pkg::OFS_CTRL_STATUS, 32'h0000_006a, rs);
      next_rise();
      `CHK(last_rise - prev_rise, P0);
      next_rise();
      `CHK(last_rise - prev_rise, P2);
      $display("deferred time base test done");
      next_rise();
      axi_wr(sct_pkg::OFS_CTRL_STATUS, 32'h0000_0008, rs);
      axi_rd(sct_pkg::OFS_CTRL_STATUS, rd, rs);
      repeat (35) @(posedge aclk);
      `CHK(osc_irq, 1'b0);
      axi_rd(sct_pkg::OFS_CTRL_STATUS, rd, rs);
      `CHK(rd[0], 1'b1);
      axi_rd(sct_pkg::OFS_CTRL_STATUS, rd, rs);
      `CHK(rd[0], 1'b0);
      $display("flag test done");
      axi_wr(sct_pkg::OFS_POWER_MODE, 32'h0000_0002, rs);
      repeat (2) @(posedge aclk);
      `CHK(power_mode, sct_pkg::SCT_HALT);
      repeat (100) @(posedge aclk);
      `CHK(power_mode, sct_pkg::SCT_HALT);
      count(4);
      `CHK(c + p, 0);
      wake();
      `CHK(power_mode, sct_pkg::SCT_RUN);
      axi_wr(sct_pkg::OFS_CTRL_STATUS, 32'h0000_0002, rs);
      next_rise();
      axi_rd(sct_pkg::OFS_CTRL_STATUS, rd, rs);
      axi_wr(sct_pkg::OFS_POWER_MODE, 32'h0000_0002, rs);
      repeat (2) @(posedge aclk);
      `CHK(power_mode, sct_pkg::SCT_ACT_HALT);
      k = 0;
      while (power_mode !== sct_pkg::SCT_RUN && k < 100) begin
         @(posedge aclk);
         k++;
      end
      `CHK(power_mode, sct_pkg::SCT_RUN);
      $display("halt test done");
      axi_wr(sct_pkg::OFS_CTRL_STATUS, 32'h0000_0010, rs);
      axi_wr(sct_pkg::OFS_POWER_MODE, 32'h0000_0001, rs);
      repeat (2) @(posedge aclk);
      `CHK(power_mode, sct_pkg::SCT_WAIT);
      count(48);
      `CHK(c, 0);
      `CHK(p, 24);
      wake();
      `CHK(power_mode, sct_pkg::SCT_RUN);
      $display("slow wait test done");
      axi_rd(8'h08, rd, rs);
      `CHK(rs, sct_pkg::RESP_SLVERR);
      `CHK(rd, 32'h0000_0000);
      axi_wr(8'h08, 32'h0000_00ff, rs);
      `CHK(rs, sct_pkg::RESP_SLVERR);
      $display("unmapped test done");
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK(power_mode, sct_pkg::SCT_RUN);
      axi_rd(sct_pkg::OFS_CTRL_STATUS, rd, rs);
      `CHK(rd, 32'h0000_0000);
      count(4);
      `CHK(c, 4);
      $display("mid-run reset test done");
      stop_test();
   end
endmodule // slow_clock_and_timebase_test
`default_nettype wire
